// ==== rtl/drc_defs.svh ====
// Purpose: named constants of the refresh controller
// Assumes: included by the package and the design modules
// Notes:   definitions only
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH

// ************************************************************
// register map
// ************************************************************
`define DRC_CTRL_ADDR   8'h36
`define DRC_CTRL_RESET  8'hc0
`define DRC_ON_BIT      7
`define DRC_XW_BIT      6
`define DRC_SEL_HI_BIT  1
`define DRC_SEL_LO_BIT  0
`define DRC_RDATA_IDLE  8'h00

// ************************************************************
// interval in clock states per code
// ************************************************************
`define DRC_IVL_00      7'h0a
`define DRC_IVL_01      7'h14
`define DRC_IVL_10      7'h28
`define DRC_IVL_11      7'h50
`define DRC_SEL_RESET   2'h0
`define DRC_CNT_W_MIN   7
`define DRC_ROW_RESET   8'h00

`endif

// ==== rtl/drc_pkg.sv ====
// Purpose: types and shared decode of the refresh controller
// Assumes: drc_defs.svh holds the numbers
// Notes:   one-hot sequencer states
`include "drc_defs.svh"

package drc_pkg;

    // one-hot refresh cycle states
    typedef enum logic [3:0] {
        DRC_IDLE = 4'h1,
        DRC_T1   = 4'h2,
        DRC_T2   = 4'h4,
        DRC_TW   = 4'h8
    } drc_state_t;

    // interval code to clock states
    function automatic logic [6:0] drc_ivl(input logic [1:0] sel);
        case (sel)
            2'h0:    drc_ivl = `DRC_IVL_00;
            2'h1:    drc_ivl = `DRC_IVL_01;
            2'h2:    drc_ivl = `DRC_IVL_10;
            default: drc_ivl = `DRC_IVL_11;
        endcase
    endfunction

endpackage

// ==== rtl/drc_tmr_if.sv ====
// Purpose: carries interval select and expiry between controller and timer
// Assumes: single clock domain
// Notes:   expire is a one-cycle pulse
`timescale 1ns/1ps

interface drc_tmr_if;
    logic [1:0] sel;
    logic       expire;
    modport tmr (input sel, output expire);
    modport ctl (output sel, input expire);
endinterface

// ==== rtl/drc_timer.sv ====
// Purpose: free-running refresh interval timer
// Assumes: sel comes from a flop in the controller
// Notes:   new sel takes effect at the next expiry
`timescale 1ns/1ps
`include "drc_defs.svh"

module drc_timer
    import drc_pkg::*;
#(
    parameter int CNT_W = 7
) (
    input  wire logic clk,
    input  wire logic rstn,
    drc_tmr_if.tmr    t
);

    // refuse counters too narrow for the longest interval
    if (CNT_W < `DRC_CNT_W_MIN) begin : g_bad_width
        $error("drc_timer: CNT_W too small");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             expire;
    } drc_tmr_t;

    drc_tmr_t q;
    drc_tmr_t next_q;

    assign t.expire = q.expire;

    // ************************************************************
    // counting
    // ************************************************************
    // runs on its own
    // counts on regardless of bus, sleep or enable state
    always_comb begin
        next_q = q;
        next_q.expire = 1'b0;
        if (q.cnt == '0) begin
            next_q.cnt    = CNT_W'(drc_ivl(t.sel) - 7'h01);
            next_q.expire = 1'b1;
        end else begin
            next_q.cnt = q.cnt - CNT_W'(1);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q.cnt    <= CNT_W'(`DRC_IVL_00 - 7'h01);
            q.expire <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    chk_timer_reload: assert property (@(posedge clk) disable iff (!rstn)
        q.expire |-> q.cnt == CNT_W'(drc_ivl($past(t.sel)) - 7'h01))
        else $error("timer did not reload on expiry");

endmodule // drc_timer

// ==== rtl/drc_refresh.sv ====
// Purpose: dynamic RAM refresh controller inserted between machine cycles
// Assumes: inputs synchronous to clk; mcycle_end pulses at each
//          machine-cycle boundary; busy stalls the bus sequencer
// Notes:   LATER_REV selects keeping one request across bus release
//
// Operation
// - drive 8-bit row on low address lines
// - interval timer runs independent of instructions
// - insert refresh at next machine-cycle boundary
// - refresh strobe low during each cycle
// - extra-wait bit 6: 2 or 3 clocks
// - bus waits never stretch the refresh cycle
// - enable bit 7 gates all insertion
// - bits 1:0 pick 10/20/40/80 states
// - reset default: every 10, 3 long
// - no refresh in reset, release, sleep, wait
// - timer keeps counting during bus release
// - sleep keeps latest request, runs after wake
// - row advances only on performed cycles
// - later revision keeps one release request
`timescale 1ns/1ps
`include "drc_defs.svh"

module drc_refresh
    import drc_pkg::*;
#(
    parameter int CNT_W     = 7,
    parameter bit LATER_REV = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       mcycle_end,
    input  wire logic       bus_release_request_n,
    input  wire logic       sleep_mode,
    input  wire logic       wait_state,
    output logic            refresh_n,
    output logic      [7:0] ref_addr,
    output logic            ref_addr_oe,
    output logic            busy
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        drc_state_t st;
        logic       refresh_on;
        logic       refresh_extra_wait;
        logic       interval_sel_hi;
        logic       interval_sel_lo;
        logic       pend;
        logic       cyc_w;
        logic [7:0] row;
        logic       refresh_n;
        logic       addr_oe;
        logic       busy;
        logic [7:0] rdata;
    } drc_main_t;

    drc_main_t q;
    drc_main_t next_q;

    drc_tmr_if tif ();

    logic released;
    logic ctrl_hit;
    logic go;
    logic cyc_done;

    // refuse a timer too narrow for the longest interval
    if (CNT_W < `DRC_CNT_W_MIN) begin : g_bad_cnt_w
        $error("drc_refresh: CNT_W too small");
    end

    // ************************************************************
    // interval timer
    // ************************************************************
    // interval select
    // the timer takes the field straight from the control flops
    assign tif.sel = {q.interval_sel_hi, q.interval_sel_lo};

    drc_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .clk  (clk),
        .rstn (rstn),
        .t    (tif.tmr)
    );

    // ************************************************************
    // decode
    // ************************************************************
    // bus held by an external requester while the request is low
    assign released = !bus_release_request_n;
    assign ctrl_hit = (io_addr == `DRC_CTRL_ADDR);

    // suppression terms
    // a start needs a boundary and a quiet bus; the wait term only
    // delays the start, it never enters the cycle itself
    assign go = (q.st == DRC_IDLE) && q.pend && q.refresh_on && mcycle_end
              && !released && !sleep_mode && !wait_state;

    // last clock of a cycle
    assign cyc_done = (q.st == DRC_TW) || ((q.st == DRC_T2) && !q.cyc_w);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_q = q;

        // control register write
        if (io_wr && ctrl_hit) begin
            next_q.refresh_on         = io_wdata[`DRC_ON_BIT];
            next_q.refresh_extra_wait = io_wdata[`DRC_XW_BIT];
            next_q.interval_sel_hi    = io_wdata[`DRC_SEL_HI_BIT];
            next_q.interval_sel_lo    = io_wdata[`DRC_SEL_LO_BIT];
        end

        // control register read, reserved bits as zero
        next_q.rdata = `DRC_RDATA_IDLE;
        if (io_rd && ctrl_hit) begin
            next_q.rdata[`DRC_ON_BIT]     = q.refresh_on;
            next_q.rdata[`DRC_XW_BIT]     = q.refresh_extra_wait;
            next_q.rdata[`DRC_SEL_HI_BIT] = q.interval_sel_hi;
            next_q.rdata[`DRC_SEL_LO_BIT] = q.interval_sel_lo;
        end

        // pending request: clears first, a fresh expiry wins last
        if (go) begin
            next_q.pend = 1'b0;
        end
        if (released && !LATER_REV) begin
            next_q.pend = 1'b0;
        end
        // timer runs on
        // one flag, so a newer request simply replaces the older one
        if (tif.expire && q.refresh_on && (!released || LATER_REV)) begin
            next_q.pend = 1'b1;
        end
        // disable drops
        // clearing here keeps a later enable from running a stale request
        if (!q.refresh_on) begin
            next_q.pend = 1'b0;
        end

        // no wait stretch
        // wait_state is not looked at once the cycle has begun
        case (q.st)
            DRC_IDLE: begin
                if (go) begin
                    next_q.st    = DRC_T1;
                    next_q.cyc_w = q.refresh_extra_wait;
                end
            end
            DRC_T1: begin
                next_q.st = DRC_T2;
            end
            DRC_T2: begin
                next_q.st = q.cyc_w ? DRC_TW : DRC_IDLE;
            end
            DRC_TW: begin
                next_q.st = DRC_IDLE;
            end
            default: begin
                next_q.st = DRC_IDLE;
            end
        endcase

        // row advance
        // only a finished cycle moves the row; missed requests do not
        if (cyc_done) begin
            next_q.row = q.row + 8'h01;
        end

        // address drive
        // outputs follow the next state so they leave a flop directly
        next_q.refresh_n = (next_q.st == DRC_IDLE);
        next_q.addr_oe   = (next_q.st != DRC_IDLE);
        next_q.busy      = (next_q.st != DRC_IDLE);
    end

    // ************************************************************
    // registers
    // ************************************************************
    // reset defaults
    // reset yields interval code 00 and the extra wait state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q.st                 <= DRC_IDLE;
            // each field is cut from the control reset byte
            q.refresh_on         <= 1'(`DRC_CTRL_RESET >> `DRC_ON_BIT);
            q.refresh_extra_wait <= 1'(`DRC_CTRL_RESET >> `DRC_XW_BIT);
            q.interval_sel_hi    <= 1'(`DRC_CTRL_RESET >> `DRC_SEL_HI_BIT);
            q.interval_sel_lo    <= 1'(`DRC_CTRL_RESET >> `DRC_SEL_LO_BIT);
            q.pend               <= 1'b0;
            q.cyc_w              <= 1'b0;
            q.row                <= `DRC_ROW_RESET;
            q.refresh_n          <= 1'b1;
            q.addr_oe            <= 1'b0;
            q.busy               <= 1'b0;
            q.rdata              <= `DRC_RDATA_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign io_rdata    = q.rdata;
    assign refresh_n   = q.refresh_n;
    assign ref_addr    = q.row;
    assign ref_addr_oe = q.addr_oe;
    assign busy        = q.busy;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_low2;
        !refresh_n [*2] ##1 refresh_n;
    endsequence

    sequence s_low3;
        !refresh_n [*3] ##1 refresh_n;
    endsequence

    // strobe length with and without the extra wait
    chk_strobe_len_long: assert property ($fell(refresh_n) && q.cyc_w |-> s_low3)
        else $error("refresh strobe not three clocks");
    chk_strobe_len_short: assert property ($fell(refresh_n) && !q.cyc_w |-> s_low2)
        else $error("refresh strobe not two clocks");

    // row moves by one exactly at the end of a cycle
    chk_row_step: assert property ($rose(refresh_n) |-> ref_addr == 8'($past(ref_addr) + 8'h01))
        else $error("row did not advance by one");
    chk_row_hold: assert property (refresh_n && $past(refresh_n) |-> $stable(ref_addr))
        else $error("row moved without a refresh");

    // address lines driven whenever the strobe is low
    chk_addr_drive: assert property (refresh_n != ref_addr_oe)
        else $error("address enable does not match strobe");

    // a start only from a clean boundary
    chk_start_cause: assert property ($fell(refresh_n) |-> $past(mcycle_end) && $past(bus_release_request_n)
        && !$past(sleep_mode) && !$past(wait_state) && $past(q.refresh_on))
        else $error("refresh started outside a clean boundary");

    // disabled controller stays silent
    chk_off_silent: assert property (!q.refresh_on && refresh_n |=> refresh_n)
        else $error("refresh started while disabled");

    // sleep latches a fresh request
    chk_sleep_latch: assert property (sleep_mode && tif.expire && q.refresh_on |=> q.pend)
        else $error("sleep request not latched");

    // release request kept or dropped by revision
    chk_release_rev: assert property (released && tif.expire && q.refresh_on |=> q.pend == LATER_REV)
        else $error("release request handling wrong");

    // expiry spacing at the shortest interval
    chk_gap_short: assert property (tif.expire && tif.sel == 2'h0 |=> (!tif.expire) [*8] ##1 !tif.expire
        ##1 tif.expire)
        else $error("shortest interval not ten states");

    chk_held_quiet: assert property ((released || sleep_mode || wait_state) && refresh_n |=> refresh_n)
        else $error("refresh started while held off");

    chk_off_drop: assert property (!q.refresh_on |=> !q.pend)
        else $error("pending request kept while disabled");

    chk_boundary_start: assert property (q.pend && q.refresh_on && (q.st == DRC_IDLE) && mcycle_end
        && bus_release_request_n && !sleep_mode && !wait_state |=> !refresh_n && busy)
        else $error("refresh not inserted at a clean boundary");

    chk_wait_ignored: assert property ((q.st == DRC_T1) && wait_state |=> (q.st == DRC_T2))
        else $error("wait state stretched a refresh cycle");

    chk_row_still: assert property (!refresh_n && !$past(refresh_n) |-> $stable(ref_addr))
        else $error("row moved during the strobe");

    chk_release_keep: assert property (released && q.pend && q.refresh_on && LATER_REV |=> q.pend)
        else $error("pending request lost during release");

endmodule // drc_refresh

// ==== dv/drc_dram_model.sv ====
// Purpose: external dynamic RAM seen from the refresh pins
// Assumes: strobe and row come from the controller, one clock
// Notes:   reports each strobe once it has ended
`timescale 1ns/1ps

module drc_dram_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        refresh_n,
    input  wire logic [7:0]  ref_addr,
    input  wire logic        ref_addr_oe,
    output logic             done,
    output logic      [7:0]  len,
    output logic      [7:0]  row,
    output logic      [15:0] gap,
    output logic             held_ok
);
    // ************************************************************
    // strobe capture
    // ************************************************************
    logic [7:0]  cnt;
    logic [15:0] since;

    // a row that moves mid-strobe would refresh the wrong row
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done    <= 1'b0;
            len     <= 8'h00;
            row     <= 8'h00;
            gap     <= 16'h0000;
            held_ok <= 1'b0;
            cnt     <= 8'h00;
            since   <= 16'h0000;
        end else begin
            done  <= 1'b0;
            since <= since + 16'h0001;
            if (!refresh_n) begin
                cnt <= cnt + 8'h01;
                if (cnt == 8'h00) begin
                    row     <= ref_addr;
                    gap     <= since;
                    since   <= 16'h0001;
                    held_ok <= ref_addr_oe;
                end else begin
                    held_ok <= held_ok & ref_addr_oe & (ref_addr == row);
                end
            end else if (cnt != 8'h00) begin
                done <= 1'b1;
                len  <= cnt;
                cnt  <= 8'h00;
            end
        end
    end
endmodule // drc_dram_model

// ==== dv/tb.sv ====
// Purpose: self-checking bench of the refresh controller
// Assumes: 10 MHz clock, reset low for 12 cycles
// Notes:   gap notes of 0 mean spacing is not judged
`timescale 1ns/1ps

`define CHK(a, b) check(32'(a), 32'(b))

module tb;
    import drc_pkg::*;
    logic        clk = 0, rstn = 0, io_wr = 0, io_rd = 0, mcycle_end = 0;
    logic        bus_release_request_n = 1, sleep_mode = 0, wait_state = 0;
    logic [7:0]  io_addr = 0, io_wdata = 0, io_rdata, ref_addr, len, row;
    logic [7:0]  exp_row = 0, cur_len = 3;
    logic        refresh_n, ref_addr_oe, busy, done, held_ok, hold_w = 0;
    logic [15:0] gap;
    logic [15:0] gap_q[$];
    int          mismatches = 0, total_checks = 0, seed = 15309;
    bit          mc_on = 1, rand_mc = 0, quiet = 0;

    drc_refresh #(.LATER_REV(1'b1)) uut (.clk(clk), .rstn(rstn), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .mcycle_end(mcycle_end), .bus_release_request_n(bus_release_request_n),
        .sleep_mode(sleep_mode), .wait_state(wait_state), .refresh_n(refresh_n),
        .ref_addr(ref_addr), .ref_addr_oe(ref_addr_oe), .busy(busy));
    drc_dram_model u_dram (.clk(clk), .rstn(rstn), .refresh_n(refresh_n),
        .ref_addr(ref_addr), .ref_addr_oe(ref_addr_oe), .done(done), .len(len),
        .row(row), .gap(gap), .held_ok(held_ok));

    // ************************************************************
    // clock, cycle boundaries and waits
    // ************************************************************
    always #50 clk = ~clk;
    // random boundaries and waits stress the insertion point
    always @(posedge clk) begin
        mcycle_end <= rand_mc ? 1'($random(seed)) : mc_on;
        wait_state <= rand_mc ? 1'($random(seed)) : hold_w;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ************************************************************
    // monitor: one note popped per finished strobe
    // ************************************************************
    always @(negedge clk) begin
        if (done === 1'b1) begin
            `CHK(row, exp_row);
            `CHK(len, cur_len);
            `CHK(held_ok, 1'b1);
            `CHK(quiet, 1'b0);
            if (gap_q.size() > 0) begin
                if (gap_q[0] != 16'h0) `CHK(gap, gap_q[0]);
                void'(gap_q.pop_front());
            end
            exp_row++;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        @(negedge clk);
        `CHK(io_rdata, e);
    endtask

    // stop boundaries first so no strobe straddles the new setting
    task automatic setup(input logic [7:0] v);
        logic [15:0] p;
        p = 16'd10 << v[1:0];
        mc_on = 0;
        repeat (6) @(negedge clk);
        wr(8'h36, v);
        @(negedge clk);
        cur_len = v[6] ? 8'd3 : 8'd2;
        quiet = !v[7];
        if (v[7]) gap_q = '{16'h0, 16'h0, 16'h0, p, p};
        mc_on = 1;
    endtask

    task automatic wait_q();
        int n;
        n = 0;
        while (gap_q.size() != 0 && n < 800) begin
            @(negedge clk);
            n++;
        end
        `CHK(gap_q.size(), 0);
    endtask

    // modes 0 release, 1 sleep, 2 wait; a held request runs on exit
    task automatic hold_off(input int m);
        int n;
        @(posedge clk);
        if (m == 0) bus_release_request_n <= 1'b0;
        if (m == 1) sleep_mode <= 1'b1;
        if (m == 2) hold_w <= 1'b1;
        repeat (8) @(negedge clk);
        quiet = 1;
        repeat (120) @(negedge clk);
        quiet = 0;
        @(posedge clk);
        bus_release_request_n <= 1'b1;
        sleep_mode <= 1'b0;
        hold_w <= 1'b0;
        n = 0;
        while (refresh_n !== 1'b0 && n < 4) begin
            @(negedge clk);
            n++;
        end
        `CHK(refresh_n, 1'b0);
        `CHK(busy, 1'b1);
        $display("test hold mode %0d done", m);
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        gap_q = '{16'h0, 16'ha, 16'ha, 16'ha};
        repeat (11) @(posedge clk);
        `CHK(refresh_n, 1'b1);
        @(posedge clk);
        rstn <= 1'b1;
        wait_q();
        rd_chk(8'h36, 8'hc0);
        rd_chk(8'h12, 8'h00);
        $display("test reset default done");
        // every interval stays within 15.625 us at 10 MHz
        for (int s = 0; s < 3; s++) begin
            setup(8'h80 | 8'(s) | {1'b0, s[0], 6'h00});
            wait_q();
        end
        setup(8'hff);
        rd_chk(8'h36, 8'hc3);
        wait_q();
        $display("test intervals done");
        setup(8'h40);
        repeat (200) @(negedge clk);
        setup(8'hc0);
        wait_q();
        $display("test disable done");
        rand_mc = 1;
        repeat (400) @(negedge clk);
        rand_mc = 0;
        $display("test random boundaries done");
        for (int m = 0; m < 3; m++) hold_off(m);
        test_done();
    end

    initial begin
        repeat (6000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule // tb
